// >>> src/ssc_pkg.sv
// Purpose: shared constants for the serial unit status and control block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low byte lanes
// Notes:   offsets, field positions and reset values live only here
`default_nettype none
package ssc_pkg;
  localparam int unsigned ADDR_W = 4;

  // register byte addresses
  localparam logic [3:0] OFS_LINE_STATUS  = 4'h0;
  localparam logic [3:0] OFS_DATA_PORT    = 4'h4;
  localparam logic [3:0] OFS_CONTROL_ONE  = 4'h8;
  localparam logic [3:0] OFS_CONTROL_TWO  = 4'hC;

  // line_status fields
  localparam int unsigned ST_TX_EMPTY  = 7;
  localparam int unsigned ST_TX_DONE   = 6;
  localparam int unsigned ST_RX_FULL   = 5;
  localparam int unsigned ST_IDLE      = 4;
  localparam int unsigned ST_OVERRUN   = 3;
  localparam int unsigned ST_NOISE     = 2;
  localparam int unsigned ST_FRAMING   = 1;
  localparam logic [7:0]  LINE_STATUS_RST = 8'hC0;

  // control_one fields
  localparam int unsigned C1_RX_NINTH = 7;
  localparam int unsigned C1_TX_NINTH = 6;
  localparam int unsigned C1_WORD_LEN = 4;
  localparam int unsigned C1_WAKE     = 3;
  localparam logic [7:0]  CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0]  CONTROL_ONE_WMASK = 8'h58;

  // control_two fields
  localparam int unsigned C2_TX_EMPTY_IE = 7;
  localparam int unsigned C2_TX_DONE_IE  = 6;
  localparam int unsigned C2_RX_IE       = 5;
  localparam int unsigned C2_IDLE_IE     = 4;
  localparam int unsigned C2_TX_EN       = 3;
  localparam int unsigned C2_RX_EN       = 2;
  localparam int unsigned C2_MUTE        = 1;
  localparam int unsigned C2_BREAK       = 0;
  localparam logic [7:0]  CONTROL_TWO_RST = 8'h00;

  // wake-up method encodings
  localparam logic WAKE_IDLE_LINE = 1'b0;
  localparam logic WAKE_ADDR_MARK = 1'b1;

  // word length encodings
  localparam logic WORD_EIGHT = 1'b0;
  localparam logic WORD_NINE  = 1'b1;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// >>> src/ssc_serial_unit_ctrl.sv
// Purpose: status and control registers of an asynchronous serial unit, AXI4-Lite slave
// Assumes: the shift-register datapath and baud logic sit outside on the same clock
// Notes:   all state freezes while i_clk_en is low; outputs come from flip-flops
// Overview of operation
// - set tx_buffer_empty when holding data moves to shift; irq if enabled
// - tx flags clear only after status access then data port write
// - no new tx load while tx_buffer_empty is still set
// - set tx_complete after data, preamble or break frame; irq if enabled
// - set rx_full when a received word becomes readable; irq if enabled
// - rx flags clear only after status access then data port read
// - idle flag on idle line; not again before rx_full, nor on waking
// - word while rx_full set: overrun set, holding kept, irq if enabled
// - noise flag set on noisy frame, raises no interrupt itself
// - framing flag on desync, heavy noise or break, no interrupt itself
// - framing plus overrun on one word sets only overrun
// - word length: 0 gives eight data bits, 1 gives nine
// - nine-bit mode stores ninth received bit and sends ninth tx bit
// - wake method: 0 idle line, 1 address mark
// - one interrupt request per enabled event, disabled enables inhibit
// - tx enable runs transmitter and gives pin its serial function
// - tx enable off then on during transmission sends a preamble after
// - rx enable switches reception; enabled receiver hunts for start bit
// - mute set or cleared by software, cleared by hardware on wake-up
// - break-send high sends breaks; set then cleared sends one break after
// - muted receiver sets no rx flags and raises no rx interrupts
// - address mark wake: msb one clears mute and sets rx_full
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
module ssc_serial_unit_ctrl (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_clk_en,
  // axi4-lite slave
  input  wire logic [3:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [3:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // transmit datapath
  output logic [7:0]       o_tx_word,
  output logic             o_tx_ninth_bit,
  output logic             o_tx_buffer_empty,
  input  wire logic        i_tx_load,
  input  wire logic        i_tx_busy,
  input  wire logic        i_tx_frame_done,
  output logic             o_tx_enable,
  output logic             o_tx_pin_serial,
  output logic             o_tx_nine_bits,
  output logic             o_tx_preamble_req,
  input  wire logic        i_tx_preamble_start,
  output logic             o_tx_break_hold,
  output logic             o_tx_break_req,
  input  wire logic        i_tx_break_start,
  // receive datapath
  input  wire logic        i_rx_word_done,
  input  wire logic [7:0]  i_rx_word,
  input  wire logic        i_rx_ninth,
  input  wire logic        i_rx_noise,
  input  wire logic        i_rx_framing,
  input  wire logic        i_rx_idle,
  output logic             o_rx_enable,
  output logic             o_rx_nine_bits,
  output logic             o_rx_mute,
  // combined request
  output logic             o_irq
);

  // register state
  logic       tx_empty_r, tx_done_r, rx_full_r, idle_r, overrun_r, noise_r, framing_r;
  logic [7:0] ctrl1_r, ctrl2_r;
  logic [7:0] tx_hold_r, rx_hold_r;
  logic       rx_ninth_r;
  logic       idle_armed_r;
  logic [1:0] tx_arm_r;
  logic [4:0] rx_arm_r;
  logic       tx_gap_r, pre_req_r, brk_req_r, irq_r;

  // bus state
  logic       wr_rdy_r, ar_rdy_r, bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ------------------------------------------------------------------ bus decode
  // ready rises only once both write channels are offered, so both are taken at one edge
  wire wr_rdy_nxt = i_s_axi_awvalid & i_s_axi_wvalid & ~wr_rdy_r & ~bvalid_r;
  wire wr_fire   = wr_rdy_r & i_s_axi_awvalid & i_s_axi_wvalid;
  wire [3:0] wr_addr = i_s_axi_awaddr;
  wire [7:0] wr_data = i_s_axi_wdata[7:0];
  wire       wr_lane = i_s_axi_wstrb[0];

  wire wr_status = wr_fire & (wr_addr == ssc_pkg::OFS_LINE_STATUS);
  wire wr_data_p = wr_fire & (wr_addr == ssc_pkg::OFS_DATA_PORT);
  wire wr_c1     = wr_fire & (wr_addr == ssc_pkg::OFS_CONTROL_ONE);
  wire wr_c2     = wr_fire & (wr_addr == ssc_pkg::OFS_CONTROL_TWO);
  wire wr_hit    = wr_status | wr_data_p | wr_c1 | wr_c2;

  wire ar_rdy_nxt = i_s_axi_arvalid & ~ar_rdy_r & ~rvalid_r;
  wire rd_fire   = ar_rdy_r & i_s_axi_arvalid;
  wire rd_status = rd_fire & (i_s_axi_araddr == ssc_pkg::OFS_LINE_STATUS);
  wire rd_data_p = rd_fire & (i_s_axi_araddr == ssc_pkg::OFS_DATA_PORT);
  wire rd_c1     = rd_fire & (i_s_axi_araddr == ssc_pkg::OFS_CONTROL_ONE);
  wire rd_c2     = rd_fire & (i_s_axi_araddr == ssc_pkg::OFS_CONTROL_TWO);
  wire rd_hit    = rd_status | rd_data_p | rd_c1 | rd_c2;

  // data port writes need lane 0; other lanes hold nothing
  wire data_wr   = wr_data_p & wr_lane;

  wire [7:0] status_vec = {tx_empty_r, tx_done_r, rx_full_r, idle_r,
                           overrun_r, noise_r, framing_r, 1'b0};
  wire [7:0] ctrl1_vec  = {rx_ninth_r, ctrl1_r[6:0] & ssc_pkg::CONTROL_ONE_WMASK[6:0]};

  wire [7:0] rd_byte = rd_status ? status_vec :
                       rd_data_p ? rx_hold_r  :
                       rd_c1     ? ctrl1_vec  :
                       rd_c2     ? ctrl2_r    : 8'h00;

  // ------------------------------------------------------------- control fields
  wire nine_bits = ctrl1_r[ssc_pkg::C1_WORD_LEN] == ssc_pkg::WORD_NINE;
  wire wake_addr = ctrl1_r[ssc_pkg::C1_WAKE] == ssc_pkg::WAKE_ADDR_MARK;
  wire tx_en     = ctrl2_r[ssc_pkg::C2_TX_EN];
  wire rx_en     = ctrl2_r[ssc_pkg::C2_RX_EN];
  wire muted     = ctrl2_r[ssc_pkg::C2_MUTE];
  wire brk       = ctrl2_r[ssc_pkg::C2_BREAK];
  wire [7:0] c2_new = wr_data;

  // -------------------------------------------------------------- transmit side
  // the datapath may only take the holding word while the empty flag is low
  wire tx_load_ok = i_tx_load & ~tx_empty_r & tx_en;
  wire [1:0] tx_kill = data_wr ? tx_arm_r : 2'b00;
  wire tx_empty_nxt = tx_load_ok | (tx_empty_r & ~tx_kill[0]);
  wire tx_done_nxt  = (i_tx_frame_done & tx_en) | (tx_done_r & ~tx_kill[1]);

  // preamble request after an off-then-on pulse of tx enable mid-word
  wire txen_fall  = wr_c2 & wr_lane & tx_en & ~c2_new[ssc_pkg::C2_TX_EN];
  wire txen_rise  = wr_c2 & wr_lane & ~tx_en & c2_new[ssc_pkg::C2_TX_EN];
  wire tx_gap_nxt = (txen_fall & i_tx_busy) | (tx_gap_r & ~txen_rise);
  wire pre_nxt    = (txen_rise & tx_gap_r) | (pre_req_r & ~i_tx_preamble_start);
  // dropping break-send still owes one break word
  wire brk_fall   = wr_c2 & wr_lane & brk & ~c2_new[ssc_pkg::C2_BREAK];
  wire brk_nxt    = brk_fall | (brk_req_r & ~i_tx_break_start);

  // --------------------------------------------------------------- receive side
  wire rx_msb      = nine_bits ? i_rx_ninth : i_rx_word[7];
  wire rx_word_ev  = i_rx_word_done & rx_en;
  wire addr_wake   = rx_word_ev & muted & wake_addr & rx_msb;
  wire idle_wake   = i_rx_idle & rx_en & muted & ~wake_addr;
  // a muted receiver touches no flags unless this very word wakes it
  wire rx_live     = rx_word_ev & (~muted | addr_wake);
  wire rx_store    = rx_live & ~rx_full_r;
  wire rx_ovr      = rx_live & rx_full_r;
  wire idle_ev     = i_rx_idle & rx_en & ~muted & idle_armed_r;

  // armed bits: 4 rx_full, 3 idle, 2 overrun, 1 noise, 0 framing
  wire rx_clr      = rd_data_p;
  wire [4:0] rx_kill = rx_clr ? rx_arm_r : 5'b0_0000;

  wire rx_full_nxt = rx_store | (rx_full_r & ~rx_kill[4]);
  wire idle_nxt    = idle_ev  | (idle_r & ~rx_kill[3]);
  wire ovr_nxt     = rx_ovr   | (overrun_r & ~rx_kill[2]);
  wire noise_nxt   = (rx_store & i_rx_noise) | (noise_r & ~rx_kill[1]);
  // overrun words never raise the framing flag
  wire frm_nxt     = (rx_store & i_rx_framing) | (framing_r & ~rx_kill[0]);
  wire idle_arm_nxt = rx_store | (idle_armed_r & ~idle_ev);

  // mute: software write wins over a hardware wake in the same cycle
  wire mute_nxt = (wr_c2 & wr_lane) ? c2_new[ssc_pkg::C2_MUTE] :
                  (addr_wake | idle_wake) ? 1'b0 : muted;

  // -------------------------------------------------------------- interrupt
  wire irq_nxt = (ctrl2_r[ssc_pkg::C2_TX_EMPTY_IE] & tx_empty_r)
               | (ctrl2_r[ssc_pkg::C2_TX_DONE_IE]  & tx_done_r)
               | (ctrl2_r[ssc_pkg::C2_RX_IE]       & (rx_full_r | overrun_r))
               | (ctrl2_r[ssc_pkg::C2_IDLE_IE]     & idle_r);

  // arming: a status access snapshots only the flags that are set right now
  wire st_access   = rd_status | wr_status;
  wire [1:0] tx_arm_nxt = st_access ? {tx_done_r, tx_empty_r} :
                          data_wr ? 2'b00 : tx_arm_r;
  wire [4:0] rx_arm_nxt = st_access ? {rx_full_r, idle_r, overrun_r, noise_r, framing_r} :
                          rx_clr ? 5'b0_0000 : rx_arm_r;

  // ------------------------------------------------------------- bus registers
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_rdy_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= ssc_pkg::RESP_OKAY;
    end else if (i_clk_en) begin
      wr_rdy_r <= wr_rdy_nxt;
      if (wr_fire) begin
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_SLVERR;
      end else if (bvalid_r && i_s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= ssc_pkg::RESP_OKAY;
    end else if (i_clk_en) begin
      ar_rdy_r <= ar_rdy_nxt;
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_byte};
        rresp_r  <= rd_hit ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_SLVERR;
      end else if (rvalid_r && i_s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------- block registers
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl1_r   <= ssc_pkg::CONTROL_ONE_RST;
      ctrl2_r   <= ssc_pkg::CONTROL_TWO_RST;
      tx_hold_r <= 8'h00;
    end else if (i_clk_en) begin
      if (wr_c1 && wr_lane) begin
        ctrl1_r <= wr_data & ssc_pkg::CONTROL_ONE_WMASK;
      end
      if (wr_c2 && wr_lane) begin
        ctrl2_r <= wr_data;
      end else begin
        ctrl2_r[ssc_pkg::C2_MUTE] <= mute_nxt;
      end
      if (data_wr) begin
        tx_hold_r <= wr_data;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_empty_r <= ssc_pkg::LINE_STATUS_RST[ssc_pkg::ST_TX_EMPTY];
      tx_done_r  <= ssc_pkg::LINE_STATUS_RST[ssc_pkg::ST_TX_DONE];
      rx_full_r  <= ssc_pkg::LINE_STATUS_RST[ssc_pkg::ST_RX_FULL];
      idle_r     <= ssc_pkg::LINE_STATUS_RST[ssc_pkg::ST_IDLE];
      overrun_r  <= ssc_pkg::LINE_STATUS_RST[ssc_pkg::ST_OVERRUN];
      noise_r    <= ssc_pkg::LINE_STATUS_RST[ssc_pkg::ST_NOISE];
      framing_r  <= ssc_pkg::LINE_STATUS_RST[ssc_pkg::ST_FRAMING];
      tx_arm_r   <= 2'b00;
      rx_arm_r   <= 5'b0_0000;
      idle_armed_r <= 1'b1;
      tx_gap_r   <= 1'b0;
      pre_req_r  <= 1'b0;
      brk_req_r  <= 1'b0;
      irq_r      <= 1'b0;
    end else if (i_clk_en) begin
      tx_empty_r <= tx_empty_nxt;
      tx_done_r  <= tx_done_nxt;
      rx_full_r  <= rx_full_nxt;
      idle_r     <= idle_nxt;
      overrun_r  <= ovr_nxt;
      noise_r    <= noise_nxt;
      framing_r  <= frm_nxt;
      tx_arm_r   <= tx_arm_nxt;
      rx_arm_r   <= rx_arm_nxt;
      idle_armed_r <= idle_arm_nxt;
      tx_gap_r   <= tx_gap_nxt;
      pre_req_r  <= pre_nxt;
      brk_req_r  <= brk_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // holding register keeps its word on overrun; the shift side is overwritten outside
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_hold_r  <= 8'h00;
      rx_ninth_r <= 1'b0;
    end else if (i_clk_en && rx_store) begin
      rx_hold_r  <= i_rx_word;
      rx_ninth_r <= nine_bits ? i_rx_ninth : rx_ninth_r;
    end
  end

  // ------------------------------------------------------------------ outputs
  assign o_s_axi_awready   = wr_rdy_r;
  assign o_s_axi_wready    = wr_rdy_r;
  assign o_s_axi_bvalid    = bvalid_r;
  assign o_s_axi_bresp     = bresp_r;
  assign o_s_axi_arready   = ar_rdy_r;
  assign o_s_axi_rvalid    = rvalid_r;
  assign o_s_axi_rdata     = rdata_r;
  assign o_s_axi_rresp     = rresp_r;
  assign o_tx_word         = tx_hold_r;
  assign o_tx_ninth_bit    = ctrl1_r[ssc_pkg::C1_TX_NINTH];
  assign o_tx_buffer_empty = tx_empty_r;
  assign o_tx_enable       = ctrl2_r[ssc_pkg::C2_TX_EN];
  assign o_tx_pin_serial   = ctrl2_r[ssc_pkg::C2_TX_EN];
  assign o_tx_nine_bits    = ctrl1_r[ssc_pkg::C1_WORD_LEN];
  assign o_rx_nine_bits    = ctrl1_r[ssc_pkg::C1_WORD_LEN];
  assign o_tx_preamble_req = pre_req_r;
  assign o_tx_break_hold   = ctrl2_r[ssc_pkg::C2_BREAK];
  assign o_tx_break_req    = brk_req_r;
  assign o_rx_enable       = ctrl2_r[ssc_pkg::C2_RX_EN];
  assign o_rx_mute         = ctrl2_r[ssc_pkg::C2_MUTE];
  assign o_irq             = irq_r;

endmodule
`default_nettype wire

// >>> bench/ssc_unit_monitor.sv
// Purpose: port-level checks for the serial unit status and control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   control bits not on ports are judged by the bench instead
`default_nettype none
module ssc_unit_monitor (
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic       i_clk_en,
  input wire logic       o_s_axi_bvalid,
  input wire logic       o_tx_buffer_empty,
  input wire logic       i_tx_load,
  input wire logic       o_tx_enable,
  input wire logic       o_tx_pin_serial,
  input wire logic       o_tx_nine_bits,
  input wire logic       o_rx_nine_bits,
  input wire logic       o_tx_preamble_req,
  input wire logic       o_tx_break_hold,
  input wire logic       o_tx_break_req,
  input wire logic       i_tx_break_start,
  input wire logic       i_rx_word_done,
  input wire logic       i_rx_idle,
  input wire logic       o_rx_mute
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_load_sets_empty: assert property (
    i_tx_load && i_clk_en && o_tx_enable && !o_tx_buffer_empty |=> o_tx_buffer_empty)
    else $error("tx load did not set the empty flag");
  a_empty_rise_cause: assert property ($rose(o_tx_buffer_empty) |-> $past(i_tx_load))
    else $error("empty flag rose without a load");
  a_empty_clear_write: assert property ($fell(o_tx_buffer_empty) |-> $rose(o_s_axi_bvalid))
    else $error("empty flag fell without a bus write");
  a_mute_fall_cause: assert property (
    $fell(o_rx_mute) |-> $rose(o_s_axi_bvalid) || $past(i_rx_idle || i_rx_word_done))
    else $error("mute cleared without cause");
  a_break_owed: assert property ($fell(o_tx_break_hold) |-> ##[0:1] o_tx_break_req)
    else $error("no break owed after break-send cleared");
  a_break_served: assert property (o_tx_break_req && i_tx_break_start |=> !o_tx_break_req)
    else $error("break request stuck after start");
  a_pin_follows: assert property (
    $changed(o_tx_pin_serial) |-> $rose(o_s_axi_bvalid) && o_tx_pin_serial == o_tx_enable)
    else $error("tx pin function changed without an enable write");
  a_len_same: assert property (
    $changed(o_tx_nine_bits) |-> $rose(o_s_axi_bvalid) && o_tx_nine_bits == o_rx_nine_bits)
    else $error("word length changed without a write or differs");
  a_preamble_cause: assert property (
    $rose(o_tx_preamble_req) |-> $rose(o_s_axi_bvalid) && o_tx_enable)
    else $error("preamble owed without tx enable write");
  c_load: cover property (i_tx_load);
  c_wake: cover property ($fell(o_rx_mute));
  c_break: cover property ($fell(o_tx_break_req));
endmodule
bind ssc_serial_unit_ctrl ssc_unit_monitor i_ssc_unit_monitor (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_tx_buffer_empty(o_tx_buffer_empty),
  .i_tx_load(i_tx_load), .o_tx_enable(o_tx_enable), .o_tx_pin_serial(o_tx_pin_serial),
  .o_tx_nine_bits(o_tx_nine_bits), .o_rx_nine_bits(o_rx_nine_bits),
  .o_tx_preamble_req(o_tx_preamble_req), .o_tx_break_hold(o_tx_break_hold),
  .o_tx_break_req(o_tx_break_req), .i_tx_break_start(i_tx_break_start),
  .i_rx_word_done(i_rx_word_done), .i_rx_idle(i_rx_idle), .o_rx_mute(o_rx_mute));
`default_nettype wire

// >>> bench/ssc_line_model.sv
// Purpose: far-side transmit shifter model for the serial unit block
// Assumes: same clock as the block; each frame lasts FRAME_CYC cycles
// Notes:   hold stalls it so flags can be inspected before a load
`default_nettype none
module ssc_line_model #(parameter int FRAME_CYC = 16) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_hold,
  input  wire logic i_tx_en,
  input  wire logic i_tx_empty,
  input  wire logic i_pre_req,
  input  wire logic i_brk_req,
  output logic      o_load,
  output logic      o_busy,
  output logic      o_done,
  output logic      o_pre_st,
  output logic      o_brk_st
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt;
  logic [3:0] ev;
  wire        go = !i_hold && i_tx_en;
  assign {o_load, o_done, o_pre_st, o_brk_st} = ev;
  assign o_busy = (cnt != 0);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 0;
      ev  <= 4'h0;
    end else begin
      ev <= 4'h0;
      if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        ev  <= 4'h4;
      end else if (go && !i_tx_empty) begin
        ev  <= 4'h8;
        cnt <= FRAME_CYC;
      end else if (go && i_brk_req) begin
        ev  <= 4'h1;
        cnt <= FRAME_CYC;
      end else if (go && i_pre_req) begin
        ev  <= 4'h2;
        cnt <= FRAME_CYC;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/async_serial_status_control_bench.sv
// Purpose: self-checking bench for the serial unit status and control block
// Assumes: AXI4-Lite master driven on rising edges, line model on the tx side
// Notes:   rx datapath pulses come straight from the bench
`default_nettype none
module async_serial_status_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rstn = 1'b0, hold = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic        arv = 1'b0, rry = 1'b0, rxd = 1'b0, r9 = 1'b0, rn = 1'b0, rf = 1'b0;
  logic        ridl = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [7:0]  rxw = 8'h00;
  logic        awrdy, wrdy, bv, arrdy, rv, t9, tbe, ten, tps, tnb, preq, bh, breq;
  logic        ren, rnb, mute, irq, ld, busy, done, pst, bst;
  logic [1:0]  br, rr, rsp;
  logic [31:0] rdat, rdv;
  logic [7:0]  txw;
  int          err_count = 0, num_checks = 0, n;
  ssc_serial_unit_ctrl i_ssc_serial_unit_ctrl (
    .i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awrdy),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'h1), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy),
    .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
    .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arrdy),
    .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .o_tx_word(txw), .o_tx_ninth_bit(t9), .o_tx_buffer_empty(tbe), .i_tx_load(ld),
    .i_tx_busy(busy), .i_tx_frame_done(done), .o_tx_enable(ten), .o_tx_pin_serial(tps),
    .o_tx_nine_bits(tnb), .o_tx_preamble_req(preq), .i_tx_preamble_start(pst),
    .o_tx_break_hold(bh), .o_tx_break_req(breq), .i_tx_break_start(bst),
    .i_rx_word_done(rxd), .i_rx_word(rxw), .i_rx_ninth(r9), .i_rx_noise(rn),
    .i_rx_framing(rf), .i_rx_idle(ridl), .o_rx_enable(ren), .o_rx_nine_bits(rnb),
    .o_rx_mute(mute), .o_irq(irq));
  ssc_line_model i_ssc_line_model (.i_clk(clk), .i_rstn(rstn), .i_hold(hold),
    .i_tx_en(ten), .i_tx_empty(tbe), .i_pre_req(preq), .i_brk_req(breq), .o_load(ld),
    .o_busy(busy), .o_done(done), .o_pre_st(pst), .o_brk_st(bst));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang;
    err_count++;
    $display("BAD %0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask
  // every channel held until its own ready; bvalid also confirms a joint take
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, 24'h00_0000, d, 3'b111};
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    rsp = br;
    if (n == 40) hang();
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'b11};
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
    rdv = rdat;
    rsp = rr;
    if (n == 40) hang();
  endtask
  task automatic wait_st(input logic [7:0] m);
    int k;
    for (k = 0; k < 40; k++) begin
      rd(4'h0);
      if ((rdv[7:0] & m) === m) break;
    end
    chk(k < 40, 1'b1, "status bit wait");
    if (k == 40) hang();
  endtask
  // between words the data and ninth lines show the inverse of the last one; noise, framing and done go low
  task automatic rx(input logic [7:0] w, input logic n9, input logic nz, input logic fr);
    @(posedge clk);
    {rxw, r9, rn, rf, rxd} <= {w, n9, nz, fr, 1'b1};
    @(posedge clk);
    {rxw, r9, rn, rf, rxd} <= {~w, ~n9, 3'b000};
  endtask
  task automatic idle;
    @(posedge clk);
    ridl <= 1'b1;
    @(posedge clk);
    ridl <= 1'b0;
  endtask
  task automatic t_reset;
    rd(4'h0);
    chk(rdv, 32'h0000_00C0, "status reset");
    rd(4'h8);
    chk(rdv, 32'h0000_0000, "control one reset");
    rd(4'hC);
    chk(rdv, 32'h0000_0000, "control two reset");
    rd(4'h2);
    chk(rsp, ssc_pkg::RESP_SLVERR, "unmapped read");
    wr(4'h2, 8'h00);
    chk(rsp, ssc_pkg::RESP_SLVERR, "unmapped write");
    $display("reset test done");
  endtask
  task automatic t_tx;
    rst();
    wr(4'hC, 8'h08);
    chk(rsp, ssc_pkg::RESP_OKAY, "write answer");
    wr(4'h4, 8'h33);
    rd(4'h0);
    chk(rdv, 32'h0000_00C0, "write without status access");
    wr(4'h4, 8'h5A);
    chk(tbe, 1'b0, "empty flag after sequence");
    chk(txw, 8'h5A, "holding word");
    rd(4'h0);
    chk(rdv, 32'h0000_0000, "tx flags after sequence");
    hold <= 1'b0;
    wait_st(8'h80);
    wait_st(8'h40);
    $display("tx test done");
  endtask
  task automatic t_irq;
    wr(4'hC, 8'h88);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "empty irq");
    wr(4'hC, 8'h48);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "complete irq");
    wr(4'hC, 8'h08);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq masked");
    $display("irq test done");
  endtask
  task automatic t_rx;
    wr(4'hC, 8'h24);
    chk(ren, 1'b1, "rx enabled");
    rx(8'h3C, 1'b0, 1'b1, 1'b0);
    rd(4'h0);
    chk(rdv, 32'h0000_00E4, "full with noise");
    chk(irq, 1'b1, "rx irq");
    rx(8'h77, 1'b0, 1'b0, 1'b1);
    rd(4'h0);
    chk(rdv, 32'h0000_00EC, "overrun only");
    rd(4'h4);
    chk(rdv, 32'h0000_003C, "holding kept");
    rd(4'h0);
    chk(rdv, 32'h0000_00C0, "rx flags cleared");
    rx(8'h11, 1'b0, 1'b0, 1'b0);
    rd(4'h4);
    rd(4'h0);
    chk(rdv, 32'h0000_00E0, "late flag survives");
    rd(4'h4);
    chk(rdv, 32'h0000_0011, "second word");
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "rx irq gone");
    idle();
    rd(4'h0);
    chk(rdv, 32'h0000_00D0, "idle flag");
    rd(4'h4);
    idle();
    rd(4'h0);
    chk(rdv, 32'h0000_00C0, "idle not set twice");
    $display("rx test done");
  endtask
  task automatic t_mute;
    wr(4'h8, 8'h08);
    wr(4'hC, 8'h26);
    rx(8'h12, 1'b0, 1'b0, 1'b0);
    rd(4'h0);
    chk(rdv, 32'h0000_00C0, "muted word");
    rx(8'h92, 1'b0, 1'b0, 1'b0);
    rd(4'h0);
    chk(rdv, 32'h0000_00E0, "address word");
    chk(mute, 1'b0, "address wake");
    rd(4'h4);
    chk(rdv, 32'h0000_0092, "address data");
    wr(4'h8, 8'h00);
    wr(4'hC, 8'h26);
    chk(mute, 1'b1, "mute by software");
    idle();
    rd(4'h0);
    chk(rdv, 32'h0000_00C0, "no idle flag on wake");
    chk(mute, 1'b0, "idle wake");
    $display("mute test done");
  endtask
  task automatic t_ctrl;
    wr(4'h8, 8'hFF);
    rd(4'h8);
    chk(rdv, 32'h0000_0058, "control one fields");
    chk({tnb, t9}, 2'b11, "nine-bit tx");
    wr(4'hC, 8'h04);
    rx(8'h01, 1'b1, 1'b0, 1'b1);
    rd(4'h8);
    chk(rdv, 32'h0000_00D8, "ninth rx bit");
    rd(4'h0);
    chk(rdv, 32'h0000_00E2, "framing flag");
    $display("control test done");
  endtask
  task automatic t_brk;
    hold <= 1'b1;
    wr(4'hC, 8'h09);
    chk(bh, 1'b1, "break hold");
    wr(4'hC, 8'h08);
    chk(breq, 1'b1, "break owed");
    hold <= 1'b0;
    for (n = 0; n < 40 && breq === 1'b1; n++) @(posedge clk);
    chk(breq, 1'b0, "break served");
    if (n == 40) hang();
    wr(4'hC, 8'h00);
    chk(tps, 1'b0, "pin back to port");
    wr(4'hC, 8'h08);
    chk(preq, 1'b1, "preamble owed");
    for (n = 0; n < 40 && preq === 1'b1; n++) @(posedge clk);
    chk(preq, 1'b0, "preamble served");
    if (n == 40) hang();
    $display("break test done");
  endtask
  initial begin
    rst();
    t_reset();
    t_tx();
    t_irq();
    t_rx();
    t_mute();
    t_ctrl();
    t_brk();
    tally_and_finish();
  end
endmodule
`default_nettype wire
